// ### inc/cadm_defs.vh
/*
 Constants for the core arithmetic datapath: ALU opcodes, status bit
 positions, core control register layout and reset, divider timing.
 Assumes inclusion by bare name from the datapath module.
*/
`ifndef CADM_DEFS_VH
`define CADM_DEFS_VH

// ALU operation codes
`define CADM_OP_ADD 4'h0
`define CADM_OP_ADC 4'h1
`define CADM_OP_SUB 4'h2
`define CADM_OP_SBB 4'h3
`define CADM_OP_AND 4'h4
`define CADM_OP_IOR 4'h5
`define CADM_OP_XOR 4'h6
`define CADM_OP_SHL 4'h7
`define CADM_OP_LSR 4'h8
`define CADM_OP_ASR 4'h9
`define CADM_OP_NOT 4'hA

// Status register bit positions
`define CADM_SR_C 0
`define CADM_SR_Z 1
`define CADM_SR_OV 2
`define CADM_SR_N 3
`define CADM_SR_DC 8

// Multiply operand kinds
`define CADM_MK_SS 3'h0
`define CADM_MK_UU 3'h1
`define CADM_MK_SU 3'h2
`define CADM_MK_US 3'h3
`define CADM_MK_SL 3'h4
`define CADM_MK_UL 3'h5
`define CADM_MK_BB 3'h6

// Accumulator operations
`define CADM_AO_NONE 3'h0
`define CADM_AO_ADD 3'h1
`define CADM_AO_SUB 3'h2
`define CADM_AO_NEG 3'h3
`define CADM_AO_MPY 3'h4
`define CADM_AO_MAC 3'h5
`define CADM_AO_MSC 3'h6
`define CADM_AO_MPYN 3'h7

// Register addresses
`define CADM_ADDR_CORE_CONTROL 4'h0
`define CADM_ADDR_STATUS 4'h1
`define CADM_ADDR_ACC_A_LO 4'h2
`define CADM_ADDR_ACC_A_MI 4'h3
`define CADM_ADDR_ACC_A_HI 4'h4
`define CADM_ADDR_ACC_B_LO 4'h5
`define CADM_ADDR_ACC_B_MI 4'h6
`define CADM_ADDR_ACC_B_HI 4'h7

// Core control fields
`define CADM_CC_IF 0
`define CADM_CC_RND 1
`define CADM_CC_ACCSEL 4
`define CADM_CC_WCLIP 5
`define CADM_CC_BCLIP 6
`define CADM_CC_ACLIP 7
`define CADM_CC_US 12
`define CADM_CC_WMASK 16'h10F3
`define CADM_CC_RESET 16'h0020

// Divider: one iteration per divisor bit
`define CADM_DIV_STEPS 5'h10

`endif

// ### logic/cadm_datapath.v
/*
 Arithmetic datapath of a 16-bit signal controller core: integer ALU with
 status flags, iterative divider, shared 17x17 multiplier with scaler and
 two 40-bit accumulators, plus the core control mode bits.
 Assumes the instruction decoder presents operands read from the working
 registers or data memory, one operation per cycle, and writes results back.
*/
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "cadm_defs.vh"

// Functional notes
// - 16-bit ALU: add, subtract, shift, logic; two's complement arithmetic.
// - ALU updates carry, zero, negative, overflow and nibble carry flags.
// - On subtract, carry means no borrow; nibble carry likewise.
// - ALU works on bytes or words as the instruction mode selects.
// - Operands come from registers or memory; results go either way.
// - Multiply: signed, unsigned, mixed, 5-bit literal and 8x8 unsigned.
// - Integer multiplies reuse the one signal-processing multiplier.
// - Byte multiply gives 16-bit result, word multiply gives 32 bits.
// - Divider: signed/unsigned 32/16 and 16/16 divides.
// - Quotient goes to working register 0, remainder to register 1.
// - Divide takes one cycle per divisor bit, same for long and short.
// - Engine: 17x17 multiplier, shifter, 40-bit adder, two accumulators.
// - Engine never runs alongside ALU or integer multiply, but the divider may; one op may use both.
// - Accumulator add, subtract and negate need no extra operand.
// - Control bits pick fractional/integer, signed/unsigned, round mode.
// - Control bits enable clipping of A, B, memory writes; select mode.
// - Multiplier scales to 1.31 fraction or 32-bit integer.
// - Unsigned operands zero-extend into bit 17, signed sign-extend.
// - 33-bit multiplier output sign-extends to 40 bits.
// - Fractional operands are Q15; 16x16 gives a 1.31 product.
module cadm_datapath #(
   parameter WIDTH = 16,
   parameter ACC_W = 40
) (
   input wire clk_sys,
   input wire resetn,
   // Register port
   input wire [3:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // Integer ALU request
   input wire alu_go,
   input wire [3:0] alu_op,
   input wire alu_byte,
   input wire [15:0] alu_a,
   input wire [15:0] alu_b,
   input wire [3:0] alu_dest_in,
   output reg [15:0] alu_result,
   output reg [3:0] alu_dest,
   output reg alu_valid,
   // Integer multiply request
   input wire mul_go,
   input wire [2:0] mul_kind,
   input wire [15:0] mul_a,
   input wire [15:0] mul_b,
   output reg [31:0] mul_result,
   output reg mul_wide,
   output reg mul_valid,
   // Divide request
   input wire div_go,
   input wire div_signed,
   input wire div_long,
   input wire [31:0] div_dividend,
   input wire [15:0] div_divisor,
   output reg [15:0] work_reg_zero,
   output reg [15:0] work_reg_one,
   output reg div_valid,
   output wire div_busy,
   // Engine request
   input wire acc_go,
   input wire [2:0] acc_op,
   input wire acc_sel_b,
   input wire [15:0] acc_x,
   input wire [15:0] acc_y,
   input wire acc_diff,
   output wire [15:0] write_data,
   output wire [15:0] status_reg
);

   localparam S_IDLE = 2'b01;
   localparam S_RUN = 2'b10;

   reg [15:0] core_control_q;
   reg [15:0] sr_q;
   reg [ACC_W-1:0] accum_a_q;
   reg [ACC_W-1:0] accum_b_q;
   reg [1:0] dstate_q;
   reg [4:0] dcnt_q;
   reg [31:0] drem_q;
   reg [15:0] dvsr_q;
   reg dqneg_q;
   reg drneg_q;

   wire unsigned_product_select = core_control_q[`CADM_CC_US];
   wire int_mode = core_control_q[`CADM_CC_IF];
   wire round_select = core_control_q[`CADM_CC_RND];
   wire acc_a_clip_enable = core_control_q[`CADM_CC_ACLIP];
   wire acc_b_clip_enable = core_control_q[`CADM_CC_BCLIP];
   wire write_clip_enable = core_control_q[`CADM_CC_WCLIP];
   wire super_clip_select = core_control_q[`CADM_CC_ACCSEL];

   // Integer ALU, byte or word
   reg [16:0] sum;
   reg [4:0] nib;
   reg [15:0] res;
   reg c_out;
   reg dc_out;
   reg ov_out;
   reg arith;
   reg sub;
   reg cin;
   reg [15:0] bo;
   wire msb = alu_byte ? res[7] : res[15];
   wire am = alu_byte ? alu_a[7] : alu_a[15];
   wire bm = alu_byte ? bo[7] : bo[15];
   wire zero = alu_byte ? (res[7:0] == 8'h00) : (res == 16'h0000);
   always @* begin
      sub = (alu_op == `CADM_OP_SUB) || (alu_op == `CADM_OP_SBB);
      arith = (alu_op <= `CADM_OP_SBB);
      bo = sub ? ~alu_b : alu_b;
      if (alu_op == `CADM_OP_ADC || alu_op == `CADM_OP_SBB)
         cin = sr_q[`CADM_SR_C];
      else
         cin = sub;
      if (alu_byte)
         sum = {8'h00, {1'b0, alu_a[7:0]} + {1'b0, bo[7:0]} + {8'h00, cin}};
      else
         sum = {1'b0, alu_a} + {1'b0, bo} + {16'h0000, cin};
      // Nibble carry; inverted operand makes it a no-borrow flag
      nib = {1'b0, alu_a[3:0]} + {1'b0, bo[3:0]} + {4'h0, cin};
      dc_out = nib[4];
      c_out = alu_byte ? sum[8] : sum[16];
      res = sum[15:0];
      case (alu_op)
         `CADM_OP_AND: res = alu_a & alu_b;
         `CADM_OP_IOR: res = alu_a | alu_b;
         `CADM_OP_XOR: res = alu_a ^ alu_b;
         `CADM_OP_NOT: res = ~alu_a;
         `CADM_OP_SHL: begin
            res = alu_a << 1;
            c_out = am;
         end
         `CADM_OP_LSR: begin
            res = alu_byte ? {9'h000, alu_a[7:1]} : {1'b0, alu_a[15:1]};
            c_out = alu_a[0];
         end
         `CADM_OP_ASR: begin
            res = alu_byte ? {8'h00, alu_a[7], alu_a[7:1]}
                           : {alu_a[15], alu_a[15:1]};
            c_out = alu_a[0];
         end
         default: ;
      endcase
      if (alu_byte)
         res = {8'h00, res[7:0]};
      ov_out = arith && (am == bm) && (msb != am);
   end

   // Shared 17x17 multiplier
   reg [16:0] ma;
   reg [16:0] mb;
   reg m_frac;
   always @* begin
      m_frac = 1'b0;
      ma = {1'b0, mul_a};
      mb = {1'b0, mul_b};
      if (acc_go) begin
         // Engine operands; diff-square uses ALU difference too
         ma = {~unsigned_product_select & (acc_diff ? res[15] : acc_x[15]),
               acc_diff ? res : acc_x};
         mb = {~unsigned_product_select & (acc_diff ? res[15] : acc_y[15]),
               acc_diff ? res : acc_y};
         m_frac = ~int_mode;
      end else begin
         // Zero or sign extension into the 17th bit
         case (mul_kind)
            `CADM_MK_SS: begin
               ma = {mul_a[15], mul_a};
               mb = {mul_b[15], mul_b};
            end
            `CADM_MK_SU: ma = {mul_a[15], mul_a};
            `CADM_MK_US: mb = {mul_b[15], mul_b};
            `CADM_MK_SL: begin
               ma = {mul_a[15], mul_a};
               mb = {12'h000, mul_b[4:0]};
            end
            `CADM_MK_UL: mb = {12'h000, mul_b[4:0]};
            `CADM_MK_BB: begin
               ma = {9'h000, mul_a[7:0]};
               mb = {9'h000, mul_b[7:0]};
            end
            default: ;
         endcase
      end
   end
   wire signed [33:0] raw = $signed(ma) * $signed(mb);
   // Fractional scaling to 1.31 or integer
   wire [32:0] scaled = m_frac ? {raw[31:0], 1'b0} : raw[32:0];
   wire [ACC_W-1:0] prod40 = {{(ACC_W-33){scaled[32]}}, scaled};

   // 40-bit adder for accumulator ops
   wire [ACC_W-1:0] acc_t = acc_sel_b ? accum_b_q : accum_a_q;
   wire [ACC_W-1:0] acc_o = acc_sel_b ? accum_a_q : accum_b_q;
   reg [ACC_W-1:0] acc_n;
   reg [ACC_W-1:0] op_l;
   reg [ACC_W-1:0] op_r;
   always @* begin
      op_l = acc_t;
      op_r = prod40;
      case (acc_op)
         `CADM_AO_ADD: op_r = acc_o;
         `CADM_AO_SUB: op_r = ~acc_o + 1'b1;
         `CADM_AO_NEG: begin
            op_l = {ACC_W{1'b0}};
            op_r = ~acc_t + 1'b1;
         end
         `CADM_AO_MPY: op_l = {ACC_W{1'b0}};
         `CADM_AO_MPYN: begin
            op_l = {ACC_W{1'b0}};
            op_r = ~prod40 + 1'b1;
         end
         `CADM_AO_MSC: op_r = ~prod40 + 1'b1;
         `CADM_AO_MAC: op_r = prod40;
         default: op_r = {ACC_W{1'b0}};
      endcase
      acc_n = op_l + op_r;
   end
   // Overflow detection and clipping
   wire ov39 = (op_l[ACC_W-1] == op_r[ACC_W-1]) &&
               (acc_n[ACC_W-1] != op_l[ACC_W-1]);
   wire ov31 = ~((&acc_n[ACC_W-1:31]) | ~(|acc_n[ACC_W-1:31]));
   wire clip_en = acc_sel_b ? acc_b_clip_enable : acc_a_clip_enable;
   reg [ACC_W-1:0] acc_w;
   always @* begin
      acc_w = acc_n;
      if (clip_en && super_clip_select && ov39)
         acc_w = op_l[ACC_W-1] ? 40'h8000000000 : 40'h7FFFFFFFFF;
      else if (clip_en && !super_clip_select && (ov31 || ov39))
         acc_w = (ov39 ? op_l[ACC_W-1] : acc_n[ACC_W-1])
                 ? 40'hFF80000000 : 40'h007FFFFFFF;
   end

   // Rounded, optionally clipped write of the other accumulator
   wire rnd_up = acc_o[15] &
                 ((acc_o[14:0] != 15'h0000) | round_select | acc_o[16]);
   wire [16:0] rnd = {acc_o[31], acc_o[31:16]} + {16'h0000, rnd_up};
   wire w_ov = (acc_o[ACC_W-1:31] != {(ACC_W-31){acc_o[31]}}) ||
               (rnd[16] != rnd[15]);
   assign write_data = (write_clip_enable && w_ov)
                       ? (acc_o[ACC_W-1] ? 16'h8000 : 16'h7FFF) : rnd[15:0];

   // Divider state machine, one step per divisor bit
   wire [31:0] dd_abs = (div_signed && div_dividend[31] && div_long)
                        ? (~div_dividend + 32'h00000001)
                        : (div_signed && div_dividend[15] && !div_long)
                        ? {16'h0000, ~div_dividend[15:0] + 16'h0001}
                        : (div_long ? div_dividend
                                    : {16'h0000, div_dividend[15:0]});
   wire dd_neg = div_signed &
                 (div_long ? div_dividend[31] : div_dividend[15]);
   wire [15:0] dv_abs = (div_signed && div_divisor[15])
                        ? (~div_divisor + 16'h0001) : div_divisor;
   wire [16:0] trial = {drem_q[31:15]} - {1'b0, dvsr_q};
   assign div_busy = dstate_q[1];
   wire [15:0] q_fin = dqneg_q ? (~drem_q[15:0] + 16'h0001) : drem_q[15:0];
   wire [15:0] r_fin = drneg_q ? (~drem_q[31:16] + 16'h0001)
                               : drem_q[31:16];

   // Registers and sequencing
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         core_control_q <= `CADM_CC_RESET;
         sr_q <= 16'h0000;
         accum_a_q <= {ACC_W{1'b0}};
         accum_b_q <= {ACC_W{1'b0}};
         dstate_q <= S_IDLE;
         dcnt_q <= 5'h00;
         drem_q <= 32'h00000000;
         dvsr_q <= 16'h0000;
         dqneg_q <= 1'b0;
         drneg_q <= 1'b0;
         reg_rdata <= 16'h0000;
         alu_result <= 16'h0000;
         alu_dest <= 4'h0;
         alu_valid <= 1'b0;
         mul_result <= 32'h00000000;
         mul_wide <= 1'b0;
         mul_valid <= 1'b0;
         work_reg_zero <= 16'h0000;
         work_reg_one <= 16'h0000;
         div_valid <= 1'b0;
      end else begin
         alu_valid <= alu_go && !acc_go;
         mul_valid <= mul_go && !acc_go;
         div_valid <= 1'b0;
         reg_rdata <= 16'h0000;
         if (alu_go && !acc_go) begin
            alu_result <= res;
            alu_dest <= alu_dest_in;
            sr_q[`CADM_SR_Z] <= zero;
            sr_q[`CADM_SR_N] <= msb;
            sr_q[`CADM_SR_C] <= c_out;
            if (arith) begin
               sr_q[`CADM_SR_OV] <= ov_out;
               sr_q[`CADM_SR_DC] <= dc_out;
            end
         end
         if (mul_go && !acc_go) begin
            // Byte product 16 bits, word product 32 bits
            mul_wide <= (mul_kind != `CADM_MK_BB);
            mul_result <= (mul_kind == `CADM_MK_BB)
                          ? {16'h0000, raw[15:0]} : raw[31:0];
         end
         if (acc_go && acc_op != `CADM_AO_NONE) begin
            if (acc_sel_b)
               accum_b_q <= acc_w;
            else
               accum_a_q <= acc_w;
         end
         case (dstate_q)
            S_IDLE: begin
               if (div_go) begin
                  // Long and short both run the full count
                  drem_q <= dd_abs;
                  dvsr_q <= dv_abs;
                  dqneg_q <= dd_neg ^ (div_signed & div_divisor[15]);
                  drneg_q <= dd_neg;
                  dcnt_q <= `CADM_DIV_STEPS;
                  dstate_q <= S_RUN;
               end
            end
            S_RUN: begin
               if (!trial[16])
                  drem_q <= {trial[15:0], drem_q[14:0], 1'b1};
               else
                  drem_q <= {drem_q[30:0], 1'b0};
               dcnt_q <= dcnt_q - 5'h01;
               if (dcnt_q == 5'h01)
                  dstate_q <= S_IDLE + 2'b00;
               if (dcnt_q == 5'h00) begin
                  dstate_q <= S_IDLE;
               end
            end
            default: dstate_q <= S_IDLE;
         endcase
         // Results land together after the last step
         if (dstate_q == S_RUN && dcnt_q == 5'h01) begin
            div_valid <= 1'b1;
         end
         if (div_valid) begin
            work_reg_zero <= q_fin;
            work_reg_one <= r_fin;
         end
         if (reg_wr && reg_addr == `CADM_ADDR_CORE_CONTROL)
            core_control_q <= reg_wdata & `CADM_CC_WMASK;
         if (reg_rd) begin
            case (reg_addr)
               `CADM_ADDR_CORE_CONTROL: reg_rdata <= core_control_q;
               `CADM_ADDR_STATUS: reg_rdata <= sr_q;
               `CADM_ADDR_ACC_A_LO: reg_rdata <= accum_a_q[15:0];
               `CADM_ADDR_ACC_A_MI: reg_rdata <= accum_a_q[31:16];
               `CADM_ADDR_ACC_A_HI: reg_rdata <= {8'h00, accum_a_q[39:32]};
               `CADM_ADDR_ACC_B_LO: reg_rdata <= accum_b_q[15:0];
               `CADM_ADDR_ACC_B_MI: reg_rdata <= accum_b_q[31:16];
               `CADM_ADDR_ACC_B_HI: reg_rdata <= {8'h00, accum_b_q[39:32]};
               default: reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   assign status_reg = sr_q;

endmodule // cadm_datapath

// ### verification/cadm_checker_assertions.sv
/*
 Checker for the datapath ports: read data, ALU, multiply, divide timing.
 Assumes one clock domain and is bound to every cadm_datapath instance.
*/
`timescale 1ns/1ps
`include "cadm_defs.vh"
module cadm_checker (
   input wire clk_sys,
   input wire resetn,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   input wire alu_go,
   input wire alu_byte,
   input wire [3:0] alu_dest_in,
   input wire [15:0] alu_result,
   input wire [3:0] alu_dest,
   input wire alu_valid,
   input wire mul_go,
   input wire [31:0] mul_result,
   input wire mul_wide,
   input wire mul_valid,
   input wire div_go,
   input wire [15:0] work_reg_zero,
   input wire [15:0] work_reg_one,
   input wire div_valid,
   input wire div_busy,
   input wire acc_go,
   input wire [15:0] status_reg
);
   default clocking dcb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   sequence s_div_start;
      div_go && !div_busy;
   endsequence
   sequence s_div_run;
      div_busy [*8];
   endsequence
   property p_rd_idle;
      !reg_rd |=> reg_rdata == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_alu_take;
      alu_go && !acc_go |=> alu_valid && alu_dest == $past(alu_dest_in);
   endproperty
   a_alu_take: assert property (p_alu_take) else $error("alu op lost");
   property p_alu_refuse;
      alu_go && acc_go |=> !alu_valid;
   endproperty
   a_alu_refuse: assert property (p_alu_refuse) else $error("alu ran with engine");
   property p_alu_flags;
      alu_valid && !$past(alu_byte) |->
         status_reg[`CADM_SR_Z] == (alu_result == 16'h0000) &&
         status_reg[`CADM_SR_N] == alu_result[15];
   endproperty
   a_alu_flags: assert property (p_alu_flags) else $error("zero or sign flag wrong");
   property p_mul_take;
      mul_go && !acc_go |=> mul_valid;
   endproperty
   a_mul_take: assert property (p_mul_take) else $error("multiply lost");
   property p_mul_byte;
      mul_valid && !mul_wide |-> mul_result[31:16] == 16'h0000;
   endproperty
   a_mul_byte: assert property (p_mul_byte) else $error("byte product too wide");
   property p_div_len;
      s_div_start |=> s_div_run ##[1:12] div_valid;
   endproperty
   a_div_len: assert property (p_div_len) else $error("divide length wrong");
   property p_div_hold;
      div_busy && !div_valid |=> $stable(work_reg_zero) && $stable(work_reg_one);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divide wrote early");
endmodule // cadm_checker
bind cadm_datapath cadm_checker cadm_checker_inst (.*);

// ### verification/cadm_wreg_model.sv
/*
 Working register array model standing beside the datapath.
 Assumes results are written back on the same clock and reset.
*/
`timescale 1ns/1ps
module cadm_wreg_model (
   input wire clk_sys,
   input wire resetn,
   input wire alu_valid,
   input wire [3:0] alu_dest,
   input wire [15:0] alu_result,
   input wire div_valid,
   input wire [15:0] work_reg_zero,
   input wire [15:0] work_reg_one,
   output wire [15:0] wreg_zero,
   output wire [15:0] wreg_one,
   output wire [15:0] wreg_three,
   output wire [31:0] pair_two
);
   reg [15:0] wreg_q [0:15];
   reg div_seen_q;
   integer i;
   assign wreg_zero = wreg_q[0];
   assign wreg_one = wreg_q[1];
   assign wreg_three = wreg_q[3];
   assign pair_two = {wreg_q[3], wreg_q[2]};
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         div_seen_q <= 1'b0;
         for (i = 0; i < 16; i = i + 1) begin
            wreg_q[i] <= 16'h0000;
         end
      end else begin
         div_seen_q <= div_valid;
         if (alu_valid) begin
            wreg_q[alu_dest] <= alu_result;
         end
         if (div_seen_q) begin
            wreg_q[0] <= work_reg_zero;
            wreg_q[1] <= work_reg_one;
         end
      end
   end
endmodule // cadm_wreg_model

// ### verification/tb_top.sv
/*
 Self-checking bench: registers, ALU, multiply, divide and engine tests.
 Assumes the datapath and working register model on one 50 MHz clock.
*/
`timescale 1ns/1ps
`include "cadm_defs.vh"
module tb_top;
   reg clk_sys = 1'b0, resetn = 1'b0;
   reg reg_wr = 1'b0, reg_rd = 1'b0, alu_go = 1'b0, alu_byte = 1'b0;
   reg mul_go = 1'b0, div_go = 1'b0, div_signed = 1'b0, div_long = 1'b0;
   reg acc_go = 1'b0, acc_sel_b = 1'b0, acc_diff = 1'b0;
   reg [3:0] reg_addr = 4'h0, alu_op = 4'h0, alu_dest_in = 4'h0;
   reg [2:0] mul_kind = 3'h0, acc_op = 3'h0;
   reg [15:0] reg_wdata = 16'h0000, alu_a = 16'h0000, alu_b = 16'h0000;
   reg [15:0] mul_a = 16'h0000, mul_b = 16'h0000, div_divisor = 16'h0001;
   reg [15:0] acc_x = 16'h0000, acc_y = 16'h0000;
   reg [31:0] div_dividend = 32'h00000000;
   wire [15:0] reg_rdata, alu_result, work_reg_zero, work_reg_one;
   wire [15:0] write_data, status_reg, wreg_zero, wreg_one, wreg_three;
   wire [31:0] mul_result;
   wire [3:0] alu_dest;
   wire alu_valid, mul_wide, mul_valid, div_valid, div_busy;
   integer err_total = 0, num_checks = 0, cyc = 0, first_n = -1;
   cadm_datapath cadm_datapath_inst (.clk_sys(clk_sys), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .alu_go(alu_go),
      .alu_op(alu_op), .alu_byte(alu_byte), .alu_a(alu_a), .alu_b(alu_b),
      .alu_dest_in(alu_dest_in), .alu_result(alu_result),
      .alu_dest(alu_dest), .alu_valid(alu_valid), .mul_go(mul_go),
      .mul_kind(mul_kind), .mul_a(mul_a), .mul_b(mul_b),
      .mul_result(mul_result), .mul_wide(mul_wide), .mul_valid(mul_valid),
      .div_go(div_go), .div_signed(div_signed), .div_long(div_long),
      .div_dividend(div_dividend), .div_divisor(div_divisor),
      .work_reg_zero(work_reg_zero), .work_reg_one(work_reg_one),
      .div_valid(div_valid), .div_busy(div_busy), .acc_go(acc_go),
      .acc_op(acc_op), .acc_sel_b(acc_sel_b), .acc_x(acc_x), .acc_y(acc_y),
      .acc_diff(acc_diff), .write_data(write_data), .status_reg(status_reg));
   cadm_wreg_model cadm_wreg_model_inst (.clk_sys(clk_sys), .resetn(resetn),
      .alu_valid(alu_valid), .alu_dest(alu_dest), .alu_result(alu_result),
      .div_valid(div_valid), .work_reg_zero(work_reg_zero),
      .work_reg_one(work_reg_one), .wreg_zero(wreg_zero),
      .wreg_one(wreg_one), .wreg_three(wreg_three), .pair_two());
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         err_total = err_total + 1;
         close_out;
      end
   end
   task automatic chk(input string nm, input logic [39:0] e, g);
      num_checks = num_checks + 1;
      if (g !== e) begin
         err_total = err_total + 1;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task wr(input [3:0] a, input [15:0] d);
      @(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk_sys) reg_wr <= 1'b0;
   endtask
   task rd(input [3:0] a, output [15:0] d);
      @(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge clk_sys) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task t_regs;
      reg [15:0] d;
      rd(4'h0, d); chk("core_control", 40'h0020, d);
      wr(4'h0, 16'hFFFF); rd(4'h0, d); chk("cc_mask", 40'h10F3, d);
      wr(4'h1, 16'hFFFF); rd(4'h1, d); chk("status", 40'h0000, d);
      rd(4'hC, d); chk("unmapped", 40'h0000, d);
      $display("test regs done");
   endtask
   task alu1(input [3:0] op, input [15:0] a, b, input bt,
         input [15:0] r, rm, f, fm);
      @(posedge clk_sys) {alu_go, alu_op, alu_a, alu_b, alu_byte,
         alu_dest_in} <= {1'b1, op, a, b, bt, op};
      @(posedge clk_sys) alu_go <= 1'b0;
      #1 chk("alu_valid", 40'h1, alu_valid);
      chk("alu_result", r & rm, alu_result & rm);
      chk("flags", f & fm, status_reg & fm);
      chk("alu_dest", op, alu_dest);
   endtask
   task t_alu;
      alu1(`CADM_OP_ADD, 16'h7FFF, 16'h0001, 0, 16'h8000, 16'hFFFF, 16'h010C, 16'h010F);
      alu1(`CADM_OP_SUB, 16'h0000, 16'h0001, 0, 16'hFFFF, 16'hFFFF, 16'h0008, 16'h010F);
      alu1(`CADM_OP_SUB, 16'h0005, 16'h0005, 0, 16'h0000, 16'hFFFF, 16'h0103, 16'h010F);
      alu1(`CADM_OP_ADC, 16'h0001, 16'h0001, 0, 16'h0003, 16'hFFFF, 16'h0000, 16'h010F);
      alu1(`CADM_OP_SBB, 16'h0005, 16'h0002, 0, 16'h0002, 16'hFFFF, 16'h0101, 16'h010F);
      alu1(`CADM_OP_ADD, 16'h00FF, 16'h0001, 1, 16'h0000, 16'h00FF, 16'h0103, 16'h010F);
      alu1(`CADM_OP_AND, 16'hF0F0, 16'h0FF0, 0, 16'h00F0, 16'hFFFF, 16'h0000, 16'h000A);
      alu1(`CADM_OP_IOR, 16'h8000, 16'h0001, 0, 16'h8001, 16'hFFFF, 16'h0008, 16'h000A);
      alu1(`CADM_OP_XOR, 16'hAAAA, 16'hAAAA, 0, 16'h0000, 16'hFFFF, 16'h0002, 16'h000A);
      alu1(`CADM_OP_SHL, 16'h4001, 16'h0001, 0, 16'h8002, 16'hFFFF, 16'h0008, 16'h000A);
      alu1(`CADM_OP_LSR, 16'h8000, 16'h0001, 0, 16'h4000, 16'hFFFF, 16'h0000, 16'h000A);
      alu1(`CADM_OP_ASR, 16'h8000, 16'h0001, 0, 16'hC000, 16'hFFFF, 16'h0008, 16'h000A);
      alu1(`CADM_OP_NOT, 16'h00FF, 16'h0000, 0, 16'hFF00, 16'hFFFF, 16'h0008, 16'h000A);
      @(posedge clk_sys) #1 chk("wreg_three", 40'h0002, wreg_three);
      $display("test alu done");
   endtask
   task mul1(input [2:0] k, input [15:0] a, b, input [31:0] r, input w);
      @(posedge clk_sys) {mul_go, mul_kind, mul_a, mul_b} <= {1'b1, k, a, b};
      @(posedge clk_sys) mul_go <= 1'b0;
      #1 chk("mul_valid", 40'h1, mul_valid);
      chk("mul_result", r, mul_result);
      chk("mul_wide", w, mul_wide);
   endtask
   task t_mul;
      mul1(`CADM_MK_SS, 16'hFFFF, 16'h0002, 32'hFFFFFFFE, 1);
      mul1(`CADM_MK_UU, 16'hFFFF, 16'h0002, 32'h0001FFFE, 1);
      mul1(`CADM_MK_SU, 16'hFFFF, 16'h8000, 32'hFFFF8000, 1);
      mul1(`CADM_MK_US, 16'h8000, 16'hFFFF, 32'hFFFF8000, 1);
      mul1(`CADM_MK_SL, 16'hFFFE, 16'hFFFF, 32'hFFFFFFC2, 1);
      mul1(`CADM_MK_UL, 16'hFFFE, 16'hFFFF, 32'h001EFFC2, 1);
      mul1(`CADM_MK_BB, 16'h12FF, 16'h34FF, 32'h0000FE01, 0);
      $display("test mul done");
   endtask
   task div1(input sg, lg, input [31:0] dd, input [15:0] dv, q, r, input ij);
      integer n;
      @(posedge clk_sys) {div_go, div_signed, div_long, div_dividend,
         div_divisor} <= {1'b1, sg, lg, dd, dv};
      n = 0;
      while (n < 40) begin
         @(posedge clk_sys) div_go <= ij && n == 3;
         #1 n = n + 1;
         if (div_valid === 1'b1) break;
      end
      if (first_n < 0) first_n = n;
      chk("div_cycles", first_n, n);
      @(posedge clk_sys) #1 chk("quotient", q, work_reg_zero);
      chk("remainder", r, work_reg_one);
      @(posedge clk_sys) #1 chk("wreg_zero", q, wreg_zero);
      chk("wreg_one", r, wreg_one);
   endtask
   task t_div;
      div1(1, 1, 32'hFFFFFF9C, 16'h0007, 16'hFFF2, 16'hFFFE, 1);
      div1(0, 1, 32'h00010000, 16'h0010, 16'h1000, 16'h0000, 0);
      div1(1, 0, 32'h55558000, 16'h0003, 16'hD556, 16'hFFFE, 0);
      div1(0, 0, 32'h5555FFFF, 16'h0100, 16'h00FF, 16'h00FF, 0);
      $display("test div done");
   endtask
   task acc1(input [2:0] op, input sb, input [15:0] x, y, input df);
      @(posedge clk_sys) {acc_go, acc_op, acc_sel_b, acc_x, acc_y, acc_diff,
         alu_go, alu_op, alu_a, alu_b} <= {1'b1, op, sb, x, y, df, df,
         `CADM_OP_SUB, x, y};
      @(posedge clk_sys) {acc_go, acc_diff, alu_go} <= 3'b000;
      #1 chk("alu_held", 40'h0, alu_valid);
   endtask
   task acc_rd(input [3:0] base, input [39:0] e);
      reg [15:0] l, m, h;
      rd(base, l); rd(base + 4'h1, m); rd(base + 4'h2, h);
      chk("accum", e, {h[7:0], m, l});
   endtask
   task t_acc;
      wr(4'h0, 16'h0000);
      acc1(`CADM_AO_MPY, 0, 16'h4000, 16'h4000, 0); acc_rd(4'h2, 40'h0020000000);
      acc1(`CADM_AO_MPY, 1, 16'h8000, 16'h8000, 0); acc_rd(4'h5, 40'h0080000000);
      acc1(`CADM_AO_MPY, 1, 16'h8000, 16'h4000, 0); acc_rd(4'h5, 40'hFFC0000000);
      acc1(`CADM_AO_ADD, 0, 16'h0000, 16'h0000, 0); acc_rd(4'h2, 40'hFFE0000000);
      acc1(`CADM_AO_SUB, 0, 16'h0000, 16'h0000, 0); acc_rd(4'h2, 40'h0020000000);
      acc1(`CADM_AO_NEG, 0, 16'h0000, 16'h0000, 0); acc_rd(4'h2, 40'hFFE0000000);
      wr(4'h0, 16'h0001);
      acc1(`CADM_AO_MAC, 0, 16'h0003, 16'h0002, 0); acc_rd(4'h2, 40'hFFE0000006);
      acc1(`CADM_AO_MSC, 0, 16'h0001, 16'h0006, 0); acc_rd(4'h2, 40'hFFE0000000);
      acc1(`CADM_AO_MPYN, 0, 16'h0002, 16'h0003, 0); acc_rd(4'h2, 40'hFFFFFFFFFA);
      acc1(`CADM_AO_MPY, 0, 16'h0007, 16'h0003, 1); acc_rd(4'h2, 40'h0000000010);
      wr(4'h0, 16'h1001);
      acc1(`CADM_AO_MPY, 0, 16'h8000, 16'h0001, 0);
      acc1(`CADM_AO_MPY, 1, 16'hFFFF, 16'h0002, 0); acc_rd(4'h5, 40'h000001FFFE);
      chk("write_data", 40'h0, write_data);
      $display("test engine done");
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      resetn <= 1'b1;
      t_regs;
      t_alu;
      t_mul;
      t_div;
      t_acc;
      close_out;
   end
endmodule // tb_top
